// file: pslpc_top.sv
// Strap latching, LEDs, power-down and isolate control with AXI4-Lite regs
// Behaviour
// [RULE_01] Interface select strap captured as hardware reset releases.
// [RULE_02] Unpulled select strap means MII; pulled high means RMII.
// [RULE_03] Reset release loads mode bit; mode then follows that bit.
// [RULE_04] Soft reset keeps the mode bit and ignores the strap.
// [RULE_05] Regulator-off strap sampled at power-on; high disables regulator.
// [RULE_06] Shared-pin select strap latched at power-on and reset release.
// [RULE_07] Unpulled shared-pin strap selects the interrupt function.
// [RULE_08] Link LED on with valid link, blinking while carrier sense high.
// [RULE_09] Speed LED on at 100 Mbps, off at 10 Mbps or isolated.
// [RULE_10] Link LED active low when regulator-off strap latched high.
// [RULE_11] Speed LED active low when shared-pin strap latched high.
// [RULE_12] Power-down bit set powers down all but management.
// [RULE_13] Clearing power-down powers up with automatic internal reset.
// [RULE_14] Energy-detect mode without energy keeps only squelch and detect.
// [RULE_15] No transmit while energy flag low; energy sets flag, powers up.
// [RULE_16] Waking restores state and interrupts if energy interrupt unmasked.
// [RULE_17] MAC tolerates losing first one or two waking packets.
// [RULE_18] Energy-detect enable zero never enters energy-detect power-down.
// [RULE_19] Isolate ignores transmit inputs; management still answered.
// [RULE_20] Isolate bit is zero after power-up.
// [RULE_21] Soft reset bit self-clears, finishing within half a second.
// [RULE_22] Interrupt output in interrupt mode is active low.
`include "pslpc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module pslpc_top #(
    parameter int BLINK_CYC = `PSLPC_BLINK_CYC,
    parameter int SRST_CYC = `PSLPC_SRST_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic por_n,
    input wire logic reduced_iface_select_strap,
    input wire logic regulator_off_strap,
    input wire logic irq_pin_select_strap,
    input wire logic link_valid,
    input wire logic carrier_sense,
    input wire logic line_energy,
    input wire logic [3:0] mac_txd,
    input wire logic mac_txen,
    input wire logic mac_txer,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [3:0] core_txd,
    output logic core_txen,
    output logic core_txer,
    output logic iface_mode_field,
    output logic regulator_enable,
    output logic irq_out_n,
    output logic fifth_tx_data_bit,
    output logic link_activity_indicator,
    output logic speed_indicator,
    output logic core_power_on,
    output logic squelch_power_on,
    output logic core_reset
);
    if (BLINK_CYC < 2 || SRST_CYC < 1 ||
        SRST_CYC > `PSLPC_SRST_MAX_NS / 20) begin : g_bad_timing
        $error("pslpc_top: bad timing parameter");
    end

    ////////////////////////////////////////////////////////////////////////
    logic por_s, rsel_s, roff_s, isel_s, link_s, crs_s, nrg_s;
    // Strap and power-on syncs run through reset so release sees live levels
    pslpc_sync2 #(.INIT(1'b0)) u_s_por (.aclk(aclk), .aresetn(1'b1),
        .ce(ce), .d(por_n), .q(por_s));
    pslpc_sync2 #(.INIT(1'b0)) u_s_rsel (.aclk(aclk), .aresetn(1'b1),
        .ce(ce), .d(reduced_iface_select_strap), .q(rsel_s));
    pslpc_sync2 #(.INIT(1'b0)) u_s_roff (.aclk(aclk), .aresetn(1'b1),
        .ce(ce), .d(regulator_off_strap), .q(roff_s));
    pslpc_sync2 #(.INIT(1'b1)) u_s_isel (.aclk(aclk), .aresetn(1'b1),
        .ce(ce), .d(irq_pin_select_strap), .q(isel_s));
    pslpc_sync2 #(.INIT(1'b0)) u_s_link (.aclk(aclk), .aresetn(aresetn),
        .ce(ce), .d(link_valid), .q(link_s));
    pslpc_sync2 #(.INIT(1'b0)) u_s_crs (.aclk(aclk), .aresetn(aresetn),
        .ce(ce), .d(carrier_sense), .q(crs_s));
    pslpc_sync2 #(.INIT(1'b0)) u_s_nrg (.aclk(aclk), .aresetn(aresetn),
        .ce(ce), .d(line_energy), .q(nrg_s));

    ////////////////////////////////////////////////////////////////////////
    // Strap capture: first enabled cycle after reset release or power-on
    logic hw_first_r, por_done_r, iface_r, roff_r, isel_r;
    logic soft_load;
    logic [31:0] wr_data_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hw_first_r <= 1'b1;
        end else if (ce) begin
            hw_first_r <= 1'b0;
        end
    end
    // Power-on latch survives hardware reset; only por_n low rearms it
    always_ff @(posedge aclk) begin
        if (!por_s) begin
            por_done_r <= 1'b0;
        end else if (ce && !por_done_r) begin
            por_done_r <= 1'b1;
            roff_r <= roff_s; // RULE_05
        end
    end
    always_ff @(posedge aclk) begin
        if (ce && (hw_first_r || (por_s && !por_done_r))) begin
            isel_r <= isel_s; // RULE_06
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            iface_r <= 1'b0; // RULE_02
        end else if (ce) begin
            if (hw_first_r) begin
                iface_r <= rsel_s; // RULE_01
            end else if (soft_load) begin
                iface_r <= wr_data_r[`PSLPC_MODE_IFACE]; // RULE_03
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: one write and one read at a time
    logic aw_hold_r, w_hold_r;
    logic [11:0] wr_addr_r;
    logic [3:0] wr_strb_r;
    logic wr_go;
    assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign soft_load = wr_go && wr_addr_r == `PSLPC_OFF_MODE && wr_strb_r[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PSLPC_RESP_OKAY;
            wr_addr_r <= 12'h000;
            wr_data_r <= 32'h0000_0000;
            wr_strb_r <= 4'h0;
        end else if (ce) begin
            s_axi_awready <= !aw_hold_r && !s_axi_awready;
            s_axi_wready <= !w_hold_r && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                s_axi_awready <= 1'b0;
                wr_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                s_axi_wready <= 1'b0;
                wr_data_r <= s_axi_wdata;
                wr_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_addr_r[11:4] == 8'h00 &&
                    wr_addr_r[1:0] == 2'b00) ? `PSLPC_RESP_OKAY :
                    `PSLPC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control bits; soft reset clears all but the mode bit and wake_r
    logic srst_r, pd_r, iso_r, spd_r, edpd_en_r, mask_r, wake_r;
    logic srst_done;
    logic wr_ctrl, wr_mode, wr_stat, wr_mask;
    assign wr_ctrl = wr_go && wr_addr_r == `PSLPC_OFF_CTRL && wr_strb_r[0];
    assign wr_mode = soft_load;
    assign wr_stat = wr_go && wr_addr_r == `PSLPC_OFF_STAT && wr_strb_r[0];
    assign wr_mask = wr_go && wr_addr_r == `PSLPC_OFF_MASK && wr_strb_r[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            srst_r <= 1'b0;
            pd_r <= 1'b0;
            iso_r <= 1'b0; // RULE_20
            spd_r <= 1'b0;
            edpd_en_r <= 1'b0;
            mask_r <= 1'b0;
        end else if (ce) begin
            if (srst_done) begin
                srst_r <= 1'b0; // RULE_21
                pd_r <= 1'b0;
                iso_r <= 1'b0;
                spd_r <= 1'b0;
                edpd_en_r <= 1'b0;
                mask_r <= 1'b0;
            end else begin
                if (wr_ctrl) begin
                    srst_r <= srst_r | wr_data_r[`PSLPC_CTRL_SOFT_RST];
                    pd_r <= wr_data_r[`PSLPC_CTRL_PWR_DOWN];
                    iso_r <= wr_data_r[`PSLPC_CTRL_ISOLATE];
                    spd_r <= wr_data_r[`PSLPC_CTRL_SPEED100];
                end
                if (wr_mode) begin
                    edpd_en_r <= wr_data_r[`PSLPC_MODE_EDPD_EN];
                end
                if (wr_mask) begin
                    mask_r <= wr_data_r[`PSLPC_MASK_ENERGY];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state machine
    pslpc_pkg::pslpc_pwr_e pwr_r, pwr_nxt;
    logic [31:0] rst_cnt_r;
    logic wake_evt;
    assign srst_done = pwr_r == pslpc_pkg::PSLPC_RST && srst_r &&
        rst_cnt_r == 32'(SRST_CYC - 1);
    always_comb begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            pslpc_pkg::PSLPC_RUN: begin
                if (srst_r) begin
                    pwr_nxt = pslpc_pkg::PSLPC_RST;
                end else if (pd_r) begin
                    pwr_nxt = pslpc_pkg::PSLPC_PD; // RULE_12
                end else if (edpd_en_r && !nrg_s) begin
                    pwr_nxt = pslpc_pkg::PSLPC_EDPD; // RULE_14 RULE_18
                end
            end
            pslpc_pkg::PSLPC_PD: begin
                if (srst_r || !pd_r) begin
                    pwr_nxt = pslpc_pkg::PSLPC_RST; // RULE_13
                end
            end
            pslpc_pkg::PSLPC_EDPD: begin
                if (srst_r || pd_r || nrg_s || !edpd_en_r) begin
                    pwr_nxt = pslpc_pkg::PSLPC_RUN; // RULE_15
                end
            end
            pslpc_pkg::PSLPC_RST: begin
                if (rst_cnt_r == 32'(SRST_CYC - 1)) begin
                    pwr_nxt = pslpc_pkg::PSLPC_RUN;
                end
            end
            default: pwr_nxt = pslpc_pkg::PSLPC_RUN;
        endcase
    end
    assign wake_evt = pwr_r == pslpc_pkg::PSLPC_EDPD && nrg_s;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_r <= pslpc_pkg::PSLPC_RUN;
            rst_cnt_r <= 32'h0000_0000;
        end else if (ce) begin
            pwr_r <= pwr_nxt;
            rst_cnt_r <= (pwr_r == pslpc_pkg::PSLPC_RST) ?
                rst_cnt_r + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    // Sticky wake flag: a set in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_r <= 1'b0;
        end else if (ce) begin
            if (wake_evt) begin
                wake_r <= 1'b1; // RULE_16
            end else if (wr_stat && wr_data_r[`PSLPC_STAT_WAKE]) begin
                wake_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PSLPC_RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `PSLPC_RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                case (s_axi_araddr)
                    `PSLPC_OFF_CTRL: s_axi_rdata <= {28'h000_0000,
                        spd_r, iso_r, pd_r, srst_r};
                    `PSLPC_OFF_MODE: s_axi_rdata <= {30'h0000_0000,
                        edpd_en_r, iface_r};
                    `PSLPC_OFF_STAT: s_axi_rdata <= {26'h000_0000, wake_r,
                        pwr_r == pslpc_pkg::PSLPC_EDPD,
                        pwr_r == pslpc_pkg::PSLPC_PD, isel_r, roff_r,
                        nrg_s};
                    `PSLPC_OFF_MASK: s_axi_rdata <= {31'h0000_0000, mask_r};
                    default: s_axi_rresp <= `PSLPC_RESP_SLVERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Datapath gating, power, interrupt
    logic running, tx_pass;
    assign running = pwr_r == pslpc_pkg::PSLPC_RUN;
    assign tx_pass = running && !iso_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_txd <= 4'h0;
            core_txen <= 1'b0;
            core_txer <= 1'b0;
            fifth_tx_data_bit <= 1'b0;
            core_power_on <= 1'b1;
            squelch_power_on <= 1'b1;
            core_reset <= 1'b1;
            iface_mode_field <= 1'b0;
            regulator_enable <= 1'b1;
            irq_out_n <= 1'b1;
        end else if (ce) begin
            // MAC signals come from logic on aclk; no synchroniser
            core_txd <= tx_pass ? mac_txd : 4'h0; // RULE_19
            core_txen <= tx_pass && mac_txen; // RULE_15 RULE_19
            core_txer <= tx_pass && mac_txer && !isel_r;
            fifth_tx_data_bit <= tx_pass && mac_txer && !isel_r;
            core_power_on <= pwr_nxt == pslpc_pkg::PSLPC_RUN ||
                pwr_nxt == pslpc_pkg::PSLPC_RST; // RULE_12 RULE_14
            squelch_power_on <= pwr_nxt != pslpc_pkg::PSLPC_PD;
            core_reset <= pwr_nxt == pslpc_pkg::PSLPC_RST; // RULE_13
            iface_mode_field <= iface_r; // RULE_04
            regulator_enable <= !(por_done_r && roff_r);
            irq_out_n <= !(isel_r && wake_r && mask_r); // RULE_07 RULE_22
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // LEDs
    logic [31:0] blink_cnt_r;
    logic blink_r, link_on, speed_on;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_cnt_r <= 32'h0000_0000;
            blink_r <= 1'b1;
        end else if (ce) begin
            if (!crs_s) begin
                blink_cnt_r <= 32'h0000_0000;
                blink_r <= 1'b1;
            end else if (blink_cnt_r == 32'(BLINK_CYC - 1)) begin
                blink_cnt_r <= 32'h0000_0000;
                blink_r <= !blink_r;
            end else begin
                blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
            end
        end
    end
    assign link_on = link_s && blink_r && running; // RULE_08
    assign speed_on = spd_r && !iso_r && running; // RULE_09
    pslpc_led u_led_link (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .on(link_on), .active_low(roff_r), // RULE_10
        .pin(link_activity_indicator));
    pslpc_led u_led_speed (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .on(speed_on), .active_low(isel_r), // RULE_11
        .pin(speed_indicator));

    ////////////////////////////////////////////////////////////////////////
    a_iso_blocks_tx: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && iso_r |=> !core_txen) // RULE_19
        else $error("tx passed while isolated");
    a_edpd_no_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        !edpd_en_r && running |=> pwr_r != pslpc_pkg::PSLPC_EDPD) // RULE_18
        else $error("edpd entered while disabled");
    a_pd_core_off: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && pwr_r == pslpc_pkg::PSLPC_PD && pd_r && !srst_r
        |=> !core_power_on) // RULE_12
        else $error("core powered in power down");
    a_pd_exit_rst: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && pwr_r == pslpc_pkg::PSLPC_PD && !pd_r |=> core_reset) // RULE_13
        else $error("no reset after power down");
    a_srst_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && srst_done |=> !srst_r && !iso_r) // RULE_21
        else $error("soft reset not self cleared");
    a_iface_strap: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && hw_first_r |=> iface_r == $past(rsel_s)) // RULE_01
        else $error("mode strap not captured");
    a_iface_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !hw_first_r && !soft_load |=> $stable(iface_r)) // RULE_04
        else $error("mode bit moved without write");
    a_led_pol: assert property (@(posedge aclk) disable iff (!aresetn)
        ce ##1 ce |=> speed_indicator == ($past(speed_on) ^ $past(isel_r)))
        // RULE_11
        else $error("speed led polarity wrong");
    a_wake_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && wake_evt && mask_r && isel_r ##1 ce |=> !irq_out_n) // RULE_16
        else $error("wake interrupt missing");
endmodule
`default_nettype wire

// file: pslpc_params.svh
// Offsets, field positions, response codes and timing counts of the strap/LED/power block
`ifndef PSLPC_PARAMS_SVH
`define PSLPC_PARAMS_SVH
`define PSLPC_OFF_CTRL 12'h000
`define PSLPC_OFF_MODE 12'h004
`define PSLPC_OFF_STAT 12'h008
`define PSLPC_OFF_MASK 12'h00c
`define PSLPC_CTRL_SOFT_RST 0
`define PSLPC_CTRL_PWR_DOWN 1
`define PSLPC_CTRL_ISOLATE 2
`define PSLPC_CTRL_SPEED100 3
`define PSLPC_MODE_IFACE 0
`define PSLPC_MODE_EDPD_EN 1
`define PSLPC_STAT_ENERGY 0
`define PSLPC_STAT_REGULATOR_OFF_STRAP 1
`define PSLPC_STAT_IRQSEL 2
`define PSLPC_STAT_PD_ACT 3
`define PSLPC_STAT_EDPD_ACT 4
`define PSLPC_STAT_WAKE 5
`define PSLPC_MASK_ENERGY 0
`define PSLPC_CLK_HZ 50000000
`define PSLPC_SRST_MAX_NS 500000000
`define PSLPC_SRST_CYC 8
`define PSLPC_BLINK_CYC 2500000
`define PSLPC_RESP_OKAY 2'b00
`define PSLPC_RESP_SLVERR 2'b10
`endif

// file: pslpc_pkg.sv
// Types shared by the strap/LED/power block
`default_nettype none
package pslpc_pkg;
    typedef enum logic [3:0] {
        PSLPC_RUN = 4'b0001,
        PSLPC_PD = 4'b0010,
        PSLPC_EDPD = 4'b0100,
        PSLPC_RST = 4'b1000
    } pslpc_pwr_e;
endpackage
`default_nettype wire

// file: pslpc_sync2.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
`default_nettype none
module pslpc_sync2 #(
    parameter logic INIT = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic meta_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= INIT;
            q <= INIT;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// file: pslpc_led.sv
// One LED driver with strap-chosen polarity
`timescale 1ns/1ns
`default_nettype none
module pslpc_led (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic on,
    input wire logic active_low,
    output logic pin
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin <= 1'b0;
        end else if (ce) begin
            pin <= on ^ active_low;
        end
    end
endmodule
`default_nettype wire

// file: pslpc_mac_model.sv
// Behavioural MAC transmit side driving the block's transmit inputs
`timescale 1ns/1ns
`default_nettype none
module pslpc_mac_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic en,
    output logic [3:0] mac_txd,
    output logic mac_txen,
    output logic mac_txer
);
    ////////////////////////////////////////////////////////////////////
    // Frames lost on wake are simply not resent; nothing here checks them
    always_ff @(posedge aclk) begin
        if (!aresetn || !en) begin
            mac_txd <= ~mac_txd;
            mac_txen <= 1'h0;
            mac_txer <= 1'h0;
        end else begin
            mac_txd <= 4'($urandom);
            mac_txen <= 1'($urandom);
            mac_txer <= 1'($urandom);
        end
    end
endmodule
`default_nettype wire

// file: pslpc_top_tb.sv
// Self-checking bench for the strap, LED and power-down block
`include "pslpc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module pslpc_top_tb;
    logic aclk, aresetn, por_n, link_valid, carrier_sense, line_energy;
    logic reduced_iface_select_strap, regulator_off_strap;
    logic irq_pin_select_strap, mac_en, rst_seen, last;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [3:0] mac_txd, core_txd, prev_d;
    logic mac_txen, mac_txer, core_txen, core_txer, prev_en, prev_er;
    logic iface_mode_field, regulator_enable, irq_out_n, fifth_tx_data_bit;
    logic link_activity_indicator, speed_indicator;
    logic core_power_on, squelch_power_on, core_reset;
    int num_errors, check_count, toggles;
    ////////////////////////////////////////////////////////////////////
    pslpc_top #(.BLINK_CYC(4), .SRST_CYC(8)) pslpc_top_inst (
        .aclk, .aresetn, .ce(1'h1), .por_n, .reduced_iface_select_strap,
        .regulator_off_strap, .irq_pin_select_strap, .link_valid,
        .carrier_sense, .line_energy, .mac_txd, .mac_txen, .mac_txer,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .core_txd, .core_txen, .core_txer, .iface_mode_field,
        .regulator_enable, .irq_out_n, .fifth_tx_data_bit,
        .link_activity_indicator, .speed_indicator, .core_power_on,
        .squelch_power_on, .core_reset);
    pslpc_mac_model pslpc_mac_model_inst (.aclk, .aresetn, .en(mac_en),
        .mac_txd, .mac_txen, .mac_txer);
    ////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'h0;
        forever #10 aclk = ~aclk;
    end
    task automatic complete_run;
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 100) begin
            num_errors++;
            $display("[FAIL] %0t wait ran out", $time);
            complete_run();
        end
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && n < 100);
        s_axi_bready <= 1'h0;
        tmo(n);
    endtask
    task automatic axr(input logic [11:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && n < 100);
        s_axi_rready <= 1'h0;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        tmo(n);
    endtask
    task automatic wait_pwr(input logic v);
        int n;
        for (n = 0; n < 100 && core_power_on !== v; n++) @(posedge aclk);
        tmo(n);
    endtask
    task automatic hw_reset(input logic rs, input logic is);
        @(posedge aclk);
        aresetn <= 1'h0;
        reduced_iface_select_strap <= rs;
        irq_pin_select_strap <= is;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (6) @(posedge aclk);
    endtask
    // Transmit path either follows the MAC one cycle late or stays zero
    task automatic tx_cmp(input logic on, input logic te);
        repeat (8) begin
            @(posedge aclk);
            prev_d = mac_txd;
            prev_en = mac_txen;
            prev_er = mac_txer && te;
            @(negedge aclk);
            chk({fifth_tx_data_bit, core_txer, core_txen, core_txd},
                on ? {prev_er, prev_er, prev_en, prev_d} : 7'h0);
        end
    endtask
    initial begin
        repeat (100000) @(posedge aclk);
        tmo(100);
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h83a5));
        {aresetn, por_n, link_valid, carrier_sense, line_energy} = 5'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, mac_en} = 3'h1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        regulator_off_strap = 1'h1;
        {reduced_iface_select_strap, irq_pin_select_strap} = 2'h3;
        num_errors = 0;
        check_count = 0;
        toggles = 0;
        repeat (2) @(posedge aclk);
        por_n <= 1'h1;
        hw_reset(1'h1, 1'h1);
        chk(iface_mode_field, 1'h1);
        chk(regulator_enable, 1'h0);
        axr(`PSLPC_OFF_CTRL);
        chk(rd[2], 1'h0);
        link_valid <= 1'h1;
        repeat (6) @(posedge aclk);
        chk(link_activity_indicator, 1'h0);
        carrier_sense <= 1'h1;
        last = link_activity_indicator;
        repeat (40) begin
            @(negedge aclk);
            toggles += int'(link_activity_indicator !== last);
            last = link_activity_indicator;
        end
        chk(32'(toggles >= 2), 32'h1);
        axw(`PSLPC_OFF_CTRL, 32'h0000_000c);
        tx_cmp(1'h0, 1'h0);
        chk(speed_indicator, 1'h1);
        axw(`PSLPC_OFF_CTRL, 32'h0000_0008);
        tx_cmp(1'h1, 1'h0);
        chk(speed_indicator, 1'h0);
        reduced_iface_select_strap <= 1'h0;
        axw(`PSLPC_OFF_CTRL, 32'h0000_0001);
        rd = 32'h0000_0001;
        for (int i = 0; i < 20 && rd[0] !== 1'h0; i++) axr(`PSLPC_OFF_CTRL);
        chk(rd[0], 1'h0);
        chk(iface_mode_field, 1'h1);
        axw(`PSLPC_OFF_CTRL, 32'h0000_0002);
        wait_pwr(1'h0);
        chk(squelch_power_on, 1'h0);
        tx_cmp(1'h0, 1'h0);
        rst_seen = 1'h0;
        axw(`PSLPC_OFF_CTRL, 32'h0000_0000);
        repeat (50) begin
            @(negedge aclk);
            rst_seen |= core_reset;
        end
        chk({rst_seen, core_power_on, core_reset}, 3'h6);
        axw(`PSLPC_OFF_MODE, 32'h0000_0001);
        repeat (10) @(posedge aclk);
        chk(core_power_on, 1'h1);
        axw(`PSLPC_OFF_MASK, 32'h0000_0001);
        axw(`PSLPC_OFF_MODE, 32'h0000_0003);
        wait_pwr(1'h0);
        chk({squelch_power_on, irq_out_n}, 2'h3);
        tx_cmp(1'h0, 1'h0);
        repeat ($urandom_range(10, 3)) @(posedge aclk);
        line_energy <= 1'h1;
        wait_pwr(1'h1);
        repeat (4) @(posedge aclk);
        chk(irq_out_n, 1'h0);
        axr(`PSLPC_OFF_STAT);
        chk(rd[5:0], 6'h27);
        axr(12'h010);
        chk(resp, `PSLPC_RESP_SLVERR);
        hw_reset(1'h0, 1'h0);
        chk({iface_mode_field, regulator_enable}, 2'h0);
        axw(`PSLPC_OFF_CTRL, 32'h0000_0008);
        repeat (4) @(posedge aclk);
        chk(speed_indicator, 1'h1);
        tx_cmp(1'h1, 1'h1);
        axw(`PSLPC_OFF_MODE, 32'h0000_0001);
        repeat (4) @(posedge aclk);
        chk(iface_mode_field, 1'h1);
        complete_run();
    end
endmodule
`default_nettype wire
